// ===== mcu_exec_regs.svh
// register offsets, opcodes, field positions and reset values of the execute core
`ifndef MCU_EXEC_REGS_SVH
`define MCU_EXEC_REGS_SVH

// apb register byte offsets
`define REG_STATUS 8'h00
`define REG_ACC 8'h04
`define REG_PC 8'h08
`define REG_FILE_PTR 8'h0C
`define REG_FILE_DATA 8'h10

// status register bit positions
`define ST_CARRY 0
`define ST_HALF_CARRY 1
`define ST_ZERO 2
`define ST_POWER_DOWN 3
`define ST_GIE 4
`define ST_ASLEEP 5

// instruction word fields
`define INSTR_OP_HI 15
`define INSTR_OP_LO 12
`define INSTR_DEST 8
`define INSTR_TARGET_HI 11

// opcodes held in bits 15:12
`define OP_IDLE_INSTRUCTION 4'h0
`define OP_LOAD_ACC_FROM_FILE 4'h1
`define OP_LOAD_ACC_LITERAL 4'h2
`define OP_STORE_ACC_TO_FILE 4'h3
`define OP_RETURN_FROM_IRQ 4'h4
`define OP_RETURN_WITH_LITERAL 4'h5
`define OP_RETURN_SUB 4'h6
`define OP_ROTATE_LEFT_CARRY 4'h7
`define OP_ROTATE_RIGHT_CARRY 4'h8
`define OP_LITERAL_MINUS_ACC 4'h9
`define OP_FILE_MINUS_ACC 4'hA
`define OP_FILE_MINUS_ACC_BORROW 4'hB
`define OP_XOR_ACC_LITERAL 4'hC
`define OP_XOR_ACC_FILE 4'hD
`define OP_SLEEP 4'hE
`define OP_CALL 4'hF

// sizes and reset values
`define STACK_DEPTH 8
`define PC_RESET 12'h000
`define ACC_RESET 8'h00
`define FILE_PTR_RESET 8'h00

`endif

// ===== mcu_exec_pkg.sv
// types shared by the execute core
package mcu_exec_pkg;

  // sequencing states of the core
  typedef enum logic [1:0] {
    st_run,
    st_ret2,
    st_sleep
  } core_state_t;

  // opcode field
  typedef logic [3:0] opcode_t;

endpackage

// ===== mcu_exec_alu.sv
// combinational datapath: rotates, subtracts and exclusive-or with flag results
`timescale 1ns/10ps
`include "mcu_exec_regs.svh"
module mcu_exec_alu (
  // operation and operands
  input wire mcu_exec_pkg::opcode_t op_i,
  input wire logic [7:0] acc_i,
  input wire logic [7:0] fval_i,
  input wire logic [7:0] lit_i,
  input wire logic carry_i,
  // results
  output logic [7:0] result_o,
  output logic carry_o,
  output logic half_carry_o,
  output logic zero_o
);

  logic [7:0] minuend; // literal or file operand
  logic borrow_in; // inverted carry for the borrow form
  logic [8:0] diff; // nine-bit difference, msb is borrow
  logic [4:0] diff_lo; // low nibble difference, msb is nibble borrow

  // subtract operand selection
  always_comb begin
    minuend = (op_i == `OP_LITERAL_MINUS_ACC) ? lit_i : fval_i;
    borrow_in = (op_i == `OP_FILE_MINUS_ACC_BORROW) ? ~carry_i : 1'b0;
    diff = {1'b0, minuend} - {1'b0, acc_i} - {8'h00, borrow_in};
    diff_lo = {1'b0, minuend[3:0]} - {1'b0, acc_i[3:0]} - {4'h0, borrow_in};
  end

  // result and flag selection per opcode
  always_comb begin
    result_o = fval_i;
    carry_o = carry_i;
    half_carry_o = ~diff_lo[4];
    case (op_i)
      `OP_LOAD_ACC_LITERAL, `OP_RETURN_WITH_LITERAL: begin
        result_o = lit_i;
      end
      `OP_ROTATE_LEFT_CARRY: begin
        result_o = {fval_i[6:0], carry_i};
        carry_o = fval_i[7];
      end
      `OP_ROTATE_RIGHT_CARRY: begin
        result_o = {carry_i, fval_i[7:1]};
        carry_o = fval_i[0];
      end
      `OP_LITERAL_MINUS_ACC, `OP_FILE_MINUS_ACC, `OP_FILE_MINUS_ACC_BORROW: begin
        result_o = diff[7:0];
        carry_o = ~diff[8]; // one means no borrow
      end
      `OP_XOR_ACC_LITERAL: begin
        result_o = acc_i ^ lit_i;
      end
      `OP_XOR_ACC_FILE: begin
        result_o = acc_i ^ fval_i;
      end
      default: begin
        result_o = fval_i;
      end
    endcase
    zero_o = (result_o == 8'h00);
  end

endmodule // mcu_exec_alu

// ===== mcu_exec_core.sv
// instruction execute core with data file, return stack and apb status access
//
// Functional notes
// - load from file: acc gets file, one cycle
// - load literal: acc gets immediate, flags kept
// - store: file gets acc, one cycle
// - idle instruction changes nothing, one cycle
// - irq return pops pc, sets enable, two cycles
// - literal return loads acc, pops pc, two cycles
// - subroutine return pops pc in two cycles
// - destination bit zero acc, one file
// - rotate left through carry, updates carry, zero
// - rotate right through carry, updates carry only
// - sleep stops clock, sets power down flag
// - literal minus acc, carry means no borrow
// - file minus acc, routed by destination bit
// - file minus acc minus inverted carry
// - xor literal into acc, zero only
// - xor file, routed, zero flag only
`timescale 1ns/10ps
`include "mcu_exec_regs.svh"
module mcu_exec_core (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // program memory side
  output logic [11:0] pc_o,
  output logic fetch_o,
  input wire logic [15:0] instr_i,
  input wire logic instr_valid_i,
  // wake and clock control
  input wire logic ext_irq_i,
  output logic core_clk_stop_o,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o
);

  mcu_exec_pkg::core_state_t state; // sequencer state
  mcu_exec_pkg::core_state_t next_state; // sequencer next state
  mcu_exec_pkg::opcode_t op; // decoded opcode
  logic [7:0] acc; // accumulator
  logic carry; // carry flag
  logic half_carry_flag; // nibble carry flag
  logic zero; // zero flag
  logic power_down_flag; // set by sleep
  logic global_irq_enable; // set by irq return
  logic [7:0] file_mem [0:255]; // data file
  logic [11:0] stack_mem [0:`STACK_DEPTH-1]; // return stack
  logic [3:0] sp; // number of stacked entries
  logic [2:0] top_idx; // index of stack top
  logic [7:0] file_ptr; // apb window into the data file
  logic take; // instruction taken this cycle
  logic [7:0] lit; // operand field
  logic dest_file; // destination bit
  logic [7:0] fval; // addressed file value
  logic [7:0] alu_res; // datapath result
  logic alu_c; // datapath carry
  logic alu_dc; // datapath half carry
  logic alu_z; // datapath zero
  logic routed; // op routes by destination bit
  logic acc_we; // core writes acc
  logic file_we; // core writes file
  logic apb_wr; // apb write completes
  logic wr_ok; // apb write not shadowed by the core
  logic [31:0] next_rdata; // read mux
  logic next_err; // unmapped address
  logic ret_irq; // taken return came from an irq

  // instruction decode from the sixteen-bit word
  always_comb begin
    take = fetch_o & instr_valid_i;
    op = instr_i[`INSTR_OP_HI:`INSTR_OP_LO];
    lit = instr_i[7:0];
    dest_file = instr_i[`INSTR_DEST];
    fval = file_mem[lit];
    top_idx = 3'(sp - 4'h1);
  end

  mcu_exec_alu u_alu (
    .op_i(op),
    .acc_i(acc),
    .fval_i(fval),
    .lit_i(lit),
    .carry_i(carry),
    .result_o(alu_res),
    .carry_o(alu_c),
    .half_carry_o(alu_dc),
    .zero_o(alu_z)
  );

  // destination routing
  always_comb begin
    routed = (op == `OP_ROTATE_LEFT_CARRY) || (op == `OP_ROTATE_RIGHT_CARRY) ||
             (op == `OP_FILE_MINUS_ACC) || (op == `OP_FILE_MINUS_ACC_BORROW) ||
             (op == `OP_XOR_ACC_FILE);
    acc_we = take & ((routed & ~dest_file) ||
             (op == `OP_LOAD_ACC_FROM_FILE) || (op == `OP_LOAD_ACC_LITERAL) ||
             (op == `OP_RETURN_WITH_LITERAL) || (op == `OP_LITERAL_MINUS_ACC) ||
             (op == `OP_XOR_ACC_LITERAL));
    file_we = take & ((routed & dest_file) || (op == `OP_STORE_ACC_TO_FILE));
    apb_wr = psel_i & penable_i & pready_o & pwrite_i;
    wr_ok = apb_wr & ~take;
  end

  // next state of the sequencer
  always_comb begin
    next_state = state;
    case (state)
      mcu_exec_pkg::st_run: begin
        if (take && ((op == `OP_RETURN_FROM_IRQ) || (op == `OP_RETURN_WITH_LITERAL) ||
            (op == `OP_RETURN_SUB))) begin
          next_state = mcu_exec_pkg::st_ret2; // second return cycle
        end else if (take && (op == `OP_SLEEP)) begin
          next_state = mcu_exec_pkg::st_sleep;
        end
      end
      mcu_exec_pkg::st_ret2: begin
        next_state = mcu_exec_pkg::st_run;
      end
      mcu_exec_pkg::st_sleep: begin
        if (ext_irq_i) begin
          next_state = mcu_exec_pkg::st_run; // only the external source wakes
        end
      end
      default: begin
        next_state = mcu_exec_pkg::st_run;
      end
    endcase
  end

  // state register, fetch strobe and clock stop
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state <= mcu_exec_pkg::st_run;
      fetch_o <= 1'b0;
      core_clk_stop_o <= 1'b0;
    end else begin
      state <= next_state;
      fetch_o <= (next_state == mcu_exec_pkg::st_run); // idle after wake runs normally
      core_clk_stop_o <= (next_state == mcu_exec_pkg::st_sleep);
    end
  end

  // program counter and return stack pointer
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      pc_o <= `PC_RESET;
      sp <= 4'h0;
    end else if (state == mcu_exec_pkg::st_ret2) begin
      pc_o <= stack_mem[top_idx]; // reload from stack top
      if (sp != 4'h0) begin
        sp <= sp - 4'h1; // pop
      end
    end else if (take && (op == `OP_CALL)) begin
      pc_o <= instr_i[`INSTR_TARGET_HI:0];
      if (sp != 4'(`STACK_DEPTH)) begin
        sp <= sp + 4'h1;
      end
    end else if (take) begin
      pc_o <= pc_o + 12'h001; // idle, sleep and ordinary ops advance
    end
  end

  // kind of return held over its second cycle, the word is gone by then
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ret_irq <= 1'b0;
    end else if (take) begin
      ret_irq <= (op == `OP_RETURN_FROM_IRQ);
    end
  end

  // stack entry write on call
  always_ff @(posedge clk_sys_i) begin
    if (take && (op == `OP_CALL) && (sp != 4'(`STACK_DEPTH))) begin
      stack_mem[sp[2:0]] <= pc_o + 12'h001;
    end
  end

  // accumulator
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      acc <= `ACC_RESET;
    end else if (acc_we) begin
      acc <= alu_res;
    end else if (wr_ok && (paddr_i == `REG_ACC)) begin
      acc <= pwdata_i[7:0];
    end
  end

  // data file, core write has priority over apb
  always_ff @(posedge clk_sys_i) begin
    if (file_we) begin
      file_mem[lit] <= (op == `OP_STORE_ACC_TO_FILE) ? acc : alu_res;
    end else if (wr_ok && (paddr_i == `REG_FILE_DATA)) begin
      file_mem[file_ptr] <= pwdata_i[7:0];
    end
  end

  // arithmetic flags
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      carry <= 1'b0;
      half_carry_flag <= 1'b0;
      zero <= 1'b0;
    end else if (take) begin
      case (op)
        `OP_ROTATE_LEFT_CARRY: begin
          carry <= alu_c;
          zero <= alu_z;
        end
        `OP_ROTATE_RIGHT_CARRY: begin
          carry <= alu_c;
        end
        `OP_LITERAL_MINUS_ACC, `OP_FILE_MINUS_ACC, `OP_FILE_MINUS_ACC_BORROW: begin
          carry <= alu_c;
          half_carry_flag <= alu_dc;
          zero <= alu_z;
        end
        `OP_XOR_ACC_LITERAL, `OP_XOR_ACC_FILE: begin
          zero <= alu_z;
        end
        default: begin
          zero <= zero; // moves, returns and idle keep flags
        end
      endcase
    end else if (wr_ok && (paddr_i == `REG_STATUS)) begin
      carry <= pwdata_i[`ST_CARRY];
      half_carry_flag <= pwdata_i[`ST_HALF_CARRY];
      zero <= pwdata_i[`ST_ZERO];
    end
  end

  // power down and interrupt enable, hardware set wins over software
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      power_down_flag <= 1'b0;
      global_irq_enable <= 1'b0;
    end else begin
      if (take && (op == `OP_SLEEP)) begin
        power_down_flag <= 1'b1;
      end else if (wr_ok && (paddr_i == `REG_STATUS)) begin
        power_down_flag <= pwdata_i[`ST_POWER_DOWN];
      end
      if ((state == mcu_exec_pkg::st_ret2) && ret_irq) begin
        global_irq_enable <= 1'b1;
      end else if (apb_wr && (paddr_i == `REG_STATUS)) begin
        global_irq_enable <= pwdata_i[`ST_GIE];
      end
    end
  end

  // apb file window pointer
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      file_ptr <= `FILE_PTR_RESET;
    end else if (apb_wr && (paddr_i == `REG_FILE_PTR)) begin
      file_ptr <= pwdata_i[7:0];
    end
  end

  // apb read mux and address decode
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_err = 1'b0;
    case (paddr_i)
      `REG_STATUS: begin
        next_rdata[`ST_CARRY] = carry;
        next_rdata[`ST_HALF_CARRY] = half_carry_flag;
        next_rdata[`ST_ZERO] = zero;
        next_rdata[`ST_POWER_DOWN] = power_down_flag;
        next_rdata[`ST_GIE] = global_irq_enable;
        next_rdata[`ST_ASLEEP] = (state == mcu_exec_pkg::st_sleep);
      end
      `REG_ACC: begin
        next_rdata[7:0] = acc;
      end
      `REG_PC: begin
        next_rdata[11:0] = pc_o;
        next_rdata[19:16] = sp;
      end
      `REG_FILE_PTR: begin
        next_rdata[7:0] = file_ptr;
      end
      `REG_FILE_DATA: begin
        next_rdata[7:0] = file_mem[file_ptr];
      end
      default: begin
        next_err = 1'b1; // unmapped
      end
    endcase
  end

  // apb answer one cycle after setup
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      pready_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= psel_i & ~penable_i;
      prdata_o <= (psel_i & ~penable_i & ~pwrite_i) ? next_rdata : 32'h0000_0000;
      pslverr_o <= psel_i & ~penable_i & next_err;
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  a_load_acc_from_file_acc_load: assert property (take && op == `OP_LOAD_ACC_FROM_FILE |=>
    acc == $past(fval) && $stable(carry) && $stable(zero))
    else $error("load from file did not copy file into acc");
  a_load_acc_literal_acc_load: assert property (take && op == `OP_LOAD_ACC_LITERAL |=>
    acc == $past(lit) && $stable(half_carry_flag) && $stable(zero))
    else $error("load literal wrong");
  a_store_file_write: assert property (take && op == `OP_STORE_ACC_TO_FILE |=>
    file_mem[$past(lit)] == $past(acc) && $stable(acc))
    else $error("store did not write acc into file");
  a_idle_no_change: assert property (take && op == `OP_IDLE_INSTRUCTION |=>
    $stable(acc) && $stable(carry) && pc_o == $past(pc_o) + 12'h001 && fetch_o)
    else $error("idle instruction changed state");
  a_irq_ret_seq: assert property (take && op == `OP_RETURN_FROM_IRQ |=>
    !fetch_o ##1 fetch_o && global_irq_enable)
    else $error("irq return not two cycles with enable set");
  a_lit_ret_acc: assert property (take && op == `OP_RETURN_WITH_LITERAL |=>
    acc == $past(lit) ##1 $stable(acc) && fetch_o)
    else $error("literal return wrong");
  a_sub_ret_pop: assert property (take && op == `OP_RETURN_SUB && sp != 4'h0 |=>
    !fetch_o ##1 sp == $past(sp, 2) - 4'h1 && $stable(zero))
    else $error("subroutine return did not pop");
  a_dest_acc_route: assert property (take && routed && !dest_file |=>
    file_mem[$past(lit)] == $past(fval) && acc == $past(alu_res))
    else $error("destination zero wrote the file");
  a_rlf_carry_out: assert property (take && op == `OP_ROTATE_LEFT_CARRY |=>
    carry == $past(fval[7]) && zero == ($past(alu_res) == 8'h00))
    else $error("rotate left flags wrong");
  a_rrf_carry_only: assert property (take && op == `OP_ROTATE_RIGHT_CARRY |=>
    carry == $past(fval[0]) && $stable(zero))
    else $error("rotate right flags wrong");
  a_sleep_power_down: assert property (take && op == `OP_SLEEP |=>
    power_down_flag && core_clk_stop_o && !fetch_o)
    else $error("sleep did not stop the core");
  a_literal_minus_acc_no_borrow: assert property (take && op == `OP_LITERAL_MINUS_ACC |=>
    carry == ($past(lit) >= $past(acc)) && acc == 8'($past(lit) - $past(acc)))
    else $error("literal subtract wrong");
  a_file_minus_acc_result: assert property (take && op == `OP_FILE_MINUS_ACC && dest_file |=>
    file_mem[$past(lit)] == 8'($past(fval) - $past(acc)))
    else $error("file subtract wrong");
  a_file_minus_acc_borrow_borrow: assert property (take && op == `OP_FILE_MINUS_ACC_BORROW |=>
    carry == ({1'b0, $past(fval)} >= {1'b0, $past(acc)} + {8'h00, ~$past(carry)}))
    else $error("subtract with borrow carry wrong");
  a_xor_acc_literal_zero_only: assert property (take && op == `OP_XOR_ACC_LITERAL |=>
    acc == ($past(acc) ^ $past(lit)) && $stable(carry))
    else $error("xor literal wrong");
  a_xor_acc_file_zero_only: assert property (take && op == `OP_XOR_ACC_FILE |=>
    zero == (($past(acc) ^ $past(fval)) == 8'h00) && $stable(half_carry_flag))
    else $error("xor file flags wrong");
  a_half_carry_nibble: assert property (take && op == `OP_FILE_MINUS_ACC |=>
    half_carry_flag == ($past(fval[3:0]) >= $past(acc[3:0])))
    else $error("half carry wrong");

endmodule // mcu_exec_core

// ===== mcu_exec_prog_model.sv
// program memory model answering the execute core's instruction fetches
`timescale 1ns/10ps
module mcu_exec_prog_model (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // bench control
  input wire logic run_i,
  input wire logic slow_i,
  // fetch side
  input wire logic [11:0] pc_i,
  output logic [15:0] instr_o,
  output logic instr_valid_o
);
  logic [15:0] mem [0:4095]; // program words, loaded by the bench
  logic phase; // alternates so slow mode offers a word every other cycle

  // start with idle words everywhere
  initial begin
    for (int a = 0; a < 4096; a++) begin
      mem[a] = 16'h0000;
    end
  end

  // phase toggle for slow answers
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      phase <= 1'b0;
    end else begin
      phase <= ~phase;
    end
  end

  // word valid only while offered; inverted pattern otherwise, never a stale copy
  assign instr_valid_o = run_i && (!slow_i || phase);
  assign instr_o = instr_valid_o ? mem[pc_i] : ~mem[pc_i];
endmodule // mcu_exec_prog_model

// ===== test_mcu_instruction_execute.sv
// self-checking bench of the execute core with a program memory model
`timescale 1ns/10ps
`include "mcu_exec_regs.svh"
module test_mcu_instruction_execute;
  // one case: op, dest, operand, start acc/file/flags, end acc/file/flags {z,dc,c}
  typedef struct {
    logic [3:0] op; logic d; logic [7:0] k; logic [7:0] a0; logic [7:0] f0; logic [2:0] s0;
    logic [7:0] a1; logic [7:0] f1; logic [2:0] s1;
  } row_t;
  localparam int NROWS = 22;
  row_t rows [NROWS] = '{
    '{4'h1, 1'b0, 8'h23, 8'h88, 8'h23, 3'h7, 8'h23, 8'h23, 3'h7},
    '{4'h1, 1'b0, 8'hFF, 8'h00, 8'h00, 3'h0, 8'h00, 8'h00, 3'h0},
    '{4'h2, 1'b0, 8'h00, 8'h88, 8'h5A, 3'h0, 8'h00, 8'h5A, 3'h0},
    '{4'h3, 1'b0, 8'h23, 8'h88, 8'h23, 3'h5, 8'h88, 8'h88, 3'h5},
    '{4'h0, 1'b0, 8'h3C, 8'h5A, 8'h3C, 3'h2, 8'h5A, 8'h3C, 3'h2},
    '{4'h7, 1'b1, 8'h23, 8'h88, 8'hE6, 3'h6, 8'h88, 8'hCC, 3'h3},
    '{4'h7, 1'b0, 8'hFF, 8'h11, 8'h80, 3'h0, 8'h00, 8'h80, 3'h5},
    '{4'h8, 1'b0, 8'h23, 8'h88, 8'h95, 3'h6, 8'h4A, 8'h95, 3'h7},
    '{4'h8, 1'b1, 8'h40, 8'h88, 8'h01, 3'h0, 8'h88, 8'h00, 3'h1},
    '{4'h9, 1'b0, 8'h02, 8'h01, 8'h77, 3'h0, 8'h01, 8'h77, 3'h3},
    '{4'h9, 1'b0, 8'h02, 8'h02, 8'h77, 3'h0, 8'h00, 8'h77, 3'h7},
    '{4'h9, 1'b0, 8'h02, 8'h03, 8'h77, 3'h7, 8'hFF, 8'h77, 3'h0},
    '{4'hA, 1'b1, 8'h23, 8'h01, 8'h33, 3'h0, 8'h01, 8'h32, 3'h3},
    '{4'hA, 1'b1, 8'h23, 8'h01, 8'h01, 3'h0, 8'h01, 8'h00, 3'h7},
    '{4'hA, 1'b1, 8'h23, 8'h05, 8'h04, 3'h7, 8'h05, 8'hFF, 3'h0},
    '{4'hA, 1'b0, 8'hFF, 8'h01, 8'h33, 3'h0, 8'h32, 8'h33, 3'h3},
    '{4'hB, 1'b1, 8'h23, 8'h01, 8'h33, 3'h1, 8'h01, 8'h32, 3'h3},
    '{4'hB, 1'b1, 8'h23, 8'h01, 8'h02, 3'h6, 8'h01, 8'h00, 3'h7},
    '{4'hB, 1'b1, 8'h23, 8'h05, 8'h04, 3'h6, 8'h05, 8'hFE, 3'h0},
    '{4'hC, 1'b0, 8'h5F, 8'hAC, 8'h00, 3'h3, 8'hF3, 8'h00, 3'h3},
    '{4'hD, 1'b1, 8'h23, 8'hAC, 8'h5F, 3'h4, 8'hAC, 8'hF3, 3'h0},
    '{4'hD, 1'b0, 8'h23, 8'hAC, 8'hAC, 3'h3, 8'h00, 8'hAC, 3'h7}
  };
  // clock, reset and bench-driven inputs
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic ext_irq_i = 1'b0;
  logic prog_run = 1'b0; // model offers words
  logic prog_slow = 1'b0; // model answers every other cycle
  // design outputs
  logic [11:0] pc_o;
  logic fetch_o;
  logic core_clk_stop_o;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic [15:0] instr_word;
  logic instr_valid;
  int n_errors = 0;
  int checks = 0;

  // 200 MHz clock
  always #2.5 clk_sys_i = ~clk_sys_i;

  mcu_exec_core mcu_exec_core_i (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .pc_o(pc_o), .fetch_o(fetch_o),
    .instr_i(instr_word), .instr_valid_i(instr_valid), .ext_irq_i(ext_irq_i),
    .core_clk_stop_o(core_clk_stop_o), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o));
  mcu_exec_prog_model mcu_exec_prog_model_i (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .run_i(prog_run), .slow_i(prog_slow),
    .pc_i(pc_o), .instr_o(instr_word), .instr_valid_o(instr_valid));

  // compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // counts, verdict, end of run
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // a wait ran out
  task automatic give_up(input string what);
    n_errors++;
    $display("Error at %0t: timeout on %s", $time, what);
    report_and_stop();
  endtask

  // one apb transfer: setup, access held until pready
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int i;
    @(posedge clk_sys_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= addr;
    pwdata_i <= wd;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_sys_i);
      if (pready_o === 1'b1) break;
    end
    if (i == 20) give_up("apb ready");
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] addr, input logic [31:0] wd);
    logic [31:0] r;
    logic e;
    apb(1'b1, addr, wd, r, e);
  endtask

  task automatic rd(input logic [7:0] addr, output logic [31:0] r);
    logic e;
    apb(1'b0, addr, 32'h0, r, e);
  endtask

  // place words at pc and let n instructions be taken
  task automatic exec(input logic [15:0] w0, input logic [15:0] w1, input int n);
    int i;
    int taken;
    taken = 0;
    @(negedge clk_sys_i);
    mcu_exec_prog_model_i.mem[pc_o] = w0;
    mcu_exec_prog_model_i.mem[pc_o + 12'h001] = w1;
    @(posedge clk_sys_i);
    prog_run <= 1'b1;
    for (i = 0; i < 50 && taken < n; i++) begin
      @(posedge clk_sys_i);
      if (fetch_o === 1'b1 && instr_valid === 1'b1) taken++;
    end
    prog_run <= 1'b0;
    if (taken < n) give_up("instruction fetch");
  endtask

  // reset values, unmapped address, read-only pc
  task automatic regs;
    logic [31:0] d;
    logic e;
    rd(`REG_ACC, d);
    check(d, 32'h0, "acc reset");
    rd(`REG_STATUS, d);
    check(d, 32'h0, "status reset");
    apb(1'b0, 8'h20, 32'h0, d, e);
    check({31'h0, e}, 32'h1, "unmapped error");
    wr(`REG_PC, 32'hFFFF_FFFF);
    rd(`REG_PC, d);
    check(d, 32'h0, "pc read only");
  endtask

  // preset state, run one table case, read everything back
  task automatic run_row(input row_t r);
    logic [31:0] d;
    wr(`REG_FILE_PTR, {24'h0, r.k});
    wr(`REG_FILE_DATA, {24'h0, r.f0});
    wr(`REG_ACC, {24'h0, r.a0});
    wr(`REG_STATUS, {29'h0, r.s0});
    exec({r.op, 3'h0, r.d, r.k}, 16'h0000, 1);
    rd(`REG_ACC, d);
    check(d, {24'h0, r.a1}, "acc result");
    rd(`REG_FILE_DATA, d);
    check(d, {24'h0, r.f1}, "file result");
    rd(`REG_STATUS, d);
    check(d, {29'h0, r.s1}, "flags");
  endtask

  // load literal then store, back to back
  task automatic back_to_back;
    logic [31:0] d;
    exec({`OP_LOAD_ACC_LITERAL, 4'h0, 8'h5A}, {`OP_STORE_ACC_TO_FILE, 4'h0, 8'h40}, 2);
    wr(`REG_FILE_PTR, 32'h40);
    rd(`REG_FILE_DATA, d);
    check(d, 32'h5A, "stored literal");
  endtask

  // call then each return form: two cycles, pc back, acc and enable effects
  task automatic returns;
    logic [31:0] d;
    logic [11:0] back;
    for (int i = 0; i < 3; i++) begin
      wr(`REG_STATUS, 32'h5);
      wr(`REG_ACC, 32'h11);
      back = pc_o + 12'h001;
      exec({`OP_CALL, 4'h8, i[3:0], 4'h0}, 16'h0000, 1);
      exec({`OP_RETURN_FROM_IRQ + i[3:0], 4'h0, 8'hC3}, 16'h0000, 1);
      @(negedge clk_sys_i);
      check({31'h0, fetch_o}, 32'h0, "fetch in second cycle");
      @(negedge clk_sys_i);
      check({31'h0, fetch_o}, 32'h1, "fetch after return");
      check({20'h0, pc_o}, {20'h0, back}, "return pc");
      rd(`REG_ACC, d);
      check(d, (i == 1) ? 32'hC3 : 32'h11, "acc after return");
      rd(`REG_STATUS, d);
      check(d, (i == 0) ? 32'h15 : 32'h5, "status after return");
    end
  endtask

  // sleep stops fetching until the external wake
  task automatic sleep_wake;
    logic [31:0] d;
    logic [11:0] p;
    wr(`REG_STATUS, 32'h0);
    p = pc_o + 12'h001;
    exec({`OP_SLEEP, 12'h000}, 16'h0000, 1);
    repeat (4) @(negedge clk_sys_i);
    check({31'h0, core_clk_stop_o}, 32'h1, "clock stop");
    check({31'h0, fetch_o}, 32'h0, "no fetch asleep");
    check({20'h0, pc_o}, {20'h0, p}, "pc after sleep");
    @(posedge clk_sys_i);
    ext_irq_i <= 1'b1;
    @(posedge clk_sys_i);
    ext_irq_i <= 1'b0;
    @(negedge clk_sys_i);
    check({31'h0, fetch_o}, 32'h1, "fetch after wake");
    check({31'h0, core_clk_stop_o}, 32'h0, "clock runs");
    exec(16'h0000, 16'h0000, 1);
    rd(`REG_STATUS, d);
    check(d, 32'h8, "power down flag");
  endtask

  // main sequence
  initial begin
    repeat (16) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    regs();
    for (int i = 0; i < NROWS; i++) begin
      prog_slow <= i[0];
      run_row(rows[i]);
    end
    prog_slow <= 1'b0;
    back_to_back();
    returns();
    sleep_wake();
    report_and_stop();
  end
endmodule // test_mcu_instruction_execute
